// [inc/pcg_pkg.sv]
// Purpose: Constants and types for the peripheral clock gate and reset controller
// Assumes: One 10 MHz system clock; AHB-Lite register access; 32-bit words
// Notes: The divider counts run on one clock; the 240 MHz PLL rate is modelled as an enable
//
// Notes on behaviour
// [R01] Bit 0 of the audio port soft reset register holds the audio core in reset while 1.
// [R02] Bit 1 of that register reads 1 while audio clocks and resets are enabled, else 0.
// [R03] The SD host functional clock is the PLL clock divided into a high then a low phase.
// [R04] Bits 10 to 8 of the divider register set the low phase to 1 to 8 PLL cycles.
// [R05] Bits 2 to 0 of the divider register set the high phase to 1 to 8 PLL cycles.
// [R06] Bits 31 to 11 and 7 to 3 of the divider register always read zero.
// [R07] Gating bit 0 lets the SD host clock run in run mode; clear stops it there.
// [R08] Gating bit 8 lets the SD host clock run in sleep mode; clear stops it there.
// [R09] Gating bit 16 reads zero and the SD host clock always stops in deep sleep.
// [R10] All other gating bits read zero and the register resets to zero, clock off.
// [R11] The audio port clock is gated per mode likewise, its bit 0 enabling run mode.
// [R12] New phase lengths take effect only at an output period boundary, so no runt pulse.
package pcg_pkg;

    localparam logic [11:0] PCG_OFS_AUDIO_GATE  = 12'h014;
    localparam logic [11:0] PCG_OFS_AUDIO_RESET = 12'h018;
    localparam logic [11:0] PCG_OFS_SD_DIVIDER  = 12'h020;
    localparam logic [11:0] PCG_OFS_SD_GATE     = 12'h024;

    localparam int PCG_BIT_SOFT_RESET   = 0;
    localparam int PCG_BIT_ENABLED_FLAG = 1;
    localparam int PCG_BIT_RUN_GATE     = 0;
    localparam int PCG_BIT_SLEEP_GATE   = 8;
    localparam int PCG_BIT_DSLEEP_GATE  = 16;
    localparam int PCG_LOW_LSB          = 8;
    localparam int PCG_HIGH_LSB         = 0;
    localparam int PCG_PHASE_W          = 3;

    localparam logic [31:0] PCG_RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] PCG_DIVIDER_MASK = 32'h0000_0707;
    localparam logic [31:0] PCG_GATE_MASK    = 32'h0000_0101;

    localparam int PCG_PLL_MHZ = 240;

    // Power modes as presented by the power manager
    typedef enum logic [1:0]
    {
        PCG_MODE_RUN    = 2'h0,
        PCG_MODE_SLEEP  = 2'h1,
        PCG_MODE_DSLEEP = 2'h2
    } pcg_mode_t;

    // Divider phase states, one-hot
    typedef enum logic [1:0]
    {
        PCG_PH_HIGH = 2'h1,
        PCG_PH_LOW  = 2'h2
    } pcg_phase_t;

endpackage

// [design/pcg_divider.sv]
// Purpose: Divides the PLL tick stream into the SD host functional clock
// Assumes: pll_tick_i marks one PLL cycle; phase codes come from registers
// Notes: Phase codes are sampled only at the start of each high phase
`timescale 1ns/1ps
module pcg_divider
(
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  pll_tick_i,
    input  wire logic                  run_i,
    input  wire logic [2:0]            high_code_i,
    input  wire logic [2:0]            low_code_i,
    output logic                       div_clk_o
);

    pcg_pkg::pcg_phase_t state;
    logic [2:0]          count;
    logic [2:0]          low_held;

    wire phase_done = (count == 3'h0);
    wire stopped    = (state == pcg_pkg::PCG_PH_LOW) && phase_done && !run_i;

    // Period walker; codes latched at period start so edits never cut a phase short
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state     <= pcg_pkg::PCG_PH_LOW;
            count     <= 3'h0;
            low_held  <= 3'h0;
            div_clk_o <= 1'b0;
        end
        else if (pll_tick_i && !stopped)
        begin
            case (state)
                pcg_pkg::PCG_PH_HIGH:
                begin
                    if (phase_done)
                    begin
                        state     <= pcg_pkg::PCG_PH_LOW;   // [R03]
                        count     <= low_held;              // [R04]
                        div_clk_o <= 1'b0;
                    end
                    else
                    begin
                        count <= count - 3'h1;
                    end
                end
                pcg_pkg::PCG_PH_LOW:
                begin
                    if (phase_done)
                    begin
                        state     <= pcg_pkg::PCG_PH_HIGH;
                        count     <= high_code_i;           // [R05] [R12]
                        low_held  <= low_code_i;            // [R12]
                        div_clk_o <= 1'b1;
                    end
                    else
                    begin
                        count <= count - 3'h1;
                    end
                end
                default:
                begin
                    state     <= pcg_pkg::PCG_PH_LOW;
                    count     <= 3'h0;
                    div_clk_o <= 1'b0;
                end
            endcase
        end
    end

endmodule

// [design/pcg_top.sv]
// Purpose: Clock gate, divider and soft reset control for audio port and SD host
// Assumes: AHB-Lite single-word slave, zero wait states, OKAY only
// Notes: Gating stops the divided clock only after a full low phase, never mid-pulse
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pcg_top
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        pll_tick_i,
    input  wire logic [1:0]  power_mode_i,
    output logic             audio_core_reset_o,
    output logic             audio_clock_enable_o,
    output logic             sd_clock_o,
    output logic             sd_clock_enable_o
);

    logic [31:0] sd_host_clock_divider;
    logic [31:0] sd_host_clock_gating;
    logic [31:0] audio_port_clock_gating;
    logic [31:0] audio_port_soft_reset;
    logic        wr_pending;
    logic [11:0] wr_addr;
    logic [1:0]  mode_meta;
    logic [1:0]  mode_sync;
    logic        tick_meta;
    logic        tick_sync;

    // Address phase decode
    wire        addr_take = hsel_i && hready_i && htrans_i[1];
    wire [11:0] rd_addr   = haddr_i[11:0];
    wire        core_enabled_flag = audio_clock_enable_o && !audio_port_soft_reset[0];

    // Mode pins and PLL tick cross in through two flops each
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mode_meta <= 2'h0;
            mode_sync <= 2'h0;
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
        end
        else
        begin
            mode_meta <= power_mode_i;
            mode_sync <= mode_meta;
            tick_meta <= pll_tick_i;
            tick_sync <= tick_meta;
        end
    end

    // Per-mode gate selection; deep sleep always stops both clocks
    wire in_run   = (mode_sync == pcg_pkg::PCG_MODE_RUN);
    wire in_sleep = (mode_sync == pcg_pkg::PCG_MODE_SLEEP);
    wire sd_run   = (in_run && sd_host_clock_gating[pcg_pkg::PCG_BIT_RUN_GATE])      // [R07]
                  || (in_sleep && sd_host_clock_gating[pcg_pkg::PCG_BIT_SLEEP_GATE]); // [R08] [R09]
    wire au_run   = (in_run && audio_port_clock_gating[pcg_pkg::PCG_BIT_RUN_GATE])   // [R11]
                  || (in_sleep && audio_port_clock_gating[pcg_pkg::PCG_BIT_SLEEP_GATE]);

    // Read mux; reserved bits never stored, so they read zero
    wire [31:0] rd_word =
        (rd_addr == pcg_pkg::PCG_OFS_SD_DIVIDER)  ? sd_host_clock_divider :   // [R06]
        (rd_addr == pcg_pkg::PCG_OFS_SD_GATE)     ? sd_host_clock_gating :    // [R10]
        (rd_addr == pcg_pkg::PCG_OFS_AUDIO_GATE)  ? audio_port_clock_gating :
        (rd_addr == pcg_pkg::PCG_OFS_AUDIO_RESET) ?
            {30'h0, core_enabled_flag, audio_port_soft_reset[0]} :          // [R02]
        32'h0000_0000;

    // Bus side: latch write address, return read data in the data phase
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_pending <= 1'b0;
            wr_addr    <= 12'h000;
            hrdata_o   <= pcg_pkg::PCG_RESET_VALUE;
        end
        else
        begin
            wr_pending <= addr_take && hwrite_i;
            if (addr_take)
            begin
                wr_addr <= rd_addr;
            end
            if (addr_take && !hwrite_i)
            begin
                hrdata_o <= rd_word;
            end
        end
    end

    // Register writes; masks keep read-only bits at zero
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sd_host_clock_divider   <= pcg_pkg::PCG_RESET_VALUE;
            sd_host_clock_gating    <= pcg_pkg::PCG_RESET_VALUE;   // [R10]
            audio_port_clock_gating <= pcg_pkg::PCG_RESET_VALUE;
            audio_port_soft_reset   <= pcg_pkg::PCG_RESET_VALUE;
        end
        else if (wr_pending)
        begin
            case (wr_addr)
                pcg_pkg::PCG_OFS_SD_DIVIDER:
                    sd_host_clock_divider <= hwdata_i & pcg_pkg::PCG_DIVIDER_MASK; // [R04] [R05]
                pcg_pkg::PCG_OFS_SD_GATE:
                    sd_host_clock_gating <= hwdata_i & pcg_pkg::PCG_GATE_MASK;     // [R09]
                pcg_pkg::PCG_OFS_AUDIO_GATE:
                    audio_port_clock_gating <= hwdata_i & pcg_pkg::PCG_GATE_MASK;
                pcg_pkg::PCG_OFS_AUDIO_RESET:
                    audio_port_soft_reset <= {31'h0, hwdata_i[0]};                // [R01]
                default:
                    audio_port_soft_reset <= audio_port_soft_reset;
            endcase
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Output controls come straight from flops
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            audio_core_reset_o   <= 1'b0;
            audio_clock_enable_o <= 1'b0;
            sd_clock_enable_o    <= 1'b0;
        end
        else
        begin
            audio_core_reset_o   <= audio_port_soft_reset[pcg_pkg::PCG_BIT_SOFT_RESET]; // [R01]
            audio_clock_enable_o <= au_run;                                            // [R11]
            sd_clock_enable_o    <= sd_run;
        end
    end

    // SD host divider, stops only at the end of a low phase
    pcg_divider u_div
    (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .pll_tick_i  (tick_sync),
        .run_i       (sd_clock_enable_o),
        .high_code_i (sd_host_clock_divider[pcg_pkg::PCG_HIGH_LSB +: pcg_pkg::PCG_PHASE_W]),
        .low_code_i  (sd_host_clock_divider[pcg_pkg::PCG_LOW_LSB +: pcg_pkg::PCG_PHASE_W]),
        .div_clk_o   (sd_clock_o)                                                  // [R03]
    );

endmodule

// [sim/pcg_props.sv]
// Purpose: Port-level checks for the clock gate and reset controller
// Assumes: Word writes only; hready is the slave's own zero-wait hreadyout
// Notes: Shadow copies of bus writes tie the reset and gate enable outputs to their cause
`timescale 1ns/1ps
module pcg_props
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        pll_tick_i,
    input wire logic [1:0]  power_mode_i,
    input wire logic        audio_core_reset_o,
    input wire logic        audio_clock_enable_o,
    input wire logic        sd_clock_o,
    input wire logic        sd_clock_enable_o
);
    logic       ph;
    logic [7:0] ad;
    logic [1:0] sg, ag;
    logic       sr;
    int         hi, lo;
    // Write mirror; phase counters restart on a tick gap, since the sync adds two cycles
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ph <= 1'b0;
            ad <= 8'h00;
            {sg, ag, sr} <= 5'h00;
            hi <= 0;
            lo <= 0;
        end
        else
        begin
            ph <= hsel_i && htrans_i[1] && hwrite_i;
            ad <= haddr_i[7:0];
            if (ph && ad == 8'h24) sg <= {hwdata_i[8], hwdata_i[0]};
            if (ph && ad == 8'h14) ag <= {hwdata_i[8], hwdata_i[0]};
            if (ph && ad == 8'h18) sr <= hwdata_i[0];
            hi <= (sd_clock_o && pll_tick_i) ? hi + 1 : 0;
            lo <= (!sd_clock_o && pll_tick_i && sd_clock_enable_o) ? lo + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    AST_CORE_SOFT_RESET: assert property (ph && ad == 8'h18 |-> ##[1:2] audio_core_reset_o == sr)
        else $error("audio reset output differs from written bit");
    AST_RUN_GATE: assert property ((power_mode_i == 2'h0 && $stable(sg))[*5]
        |-> sd_clock_enable_o == sg[0]) else $error("run mode sd gate wrong");
    AST_SLEEP_GATE: assert property ((power_mode_i == 2'h1 && $stable(sg))[*5]
        |-> sd_clock_enable_o == sg[1]) else $error("sleep mode sd gate wrong");
    AST_DSLEEP_OFF: assert property ((power_mode_i == 2'h2)[*5] |-> !sd_clock_enable_o)
        else $error("sd gate open in deep sleep");
    AST_AUDIO_GATE: assert property ((power_mode_i == 2'h0 && $stable(ag))[*5]
        |-> audio_clock_enable_o == ag[0]) else $error("run mode audio gate wrong");
    AST_STOPPED: assert property (!sd_clock_enable_o [*3] |-> !$rose(sd_clock_o))
        else $error("sd clock rose while gated off");
    AST_HIGH_MAX: assert property (hi <= 11) else $error("sd clock high too long");
    AST_LOW_MAX: assert property (lo <= 12) else $error("sd clock low too long");
    cover property ($rose(sd_clock_o));
    cover property ($rose(audio_core_reset_o));
    cover property ($fell(sd_clock_enable_o));
endmodule
bind pcg_top pcg_props pcg_props_i (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .pll_tick_i(pll_tick_i), .power_mode_i(power_mode_i), .sd_clock_o(sd_clock_o),
    .audio_core_reset_o(audio_core_reset_o), .audio_clock_enable_o(audio_clock_enable_o),
    .sd_clock_enable_o(sd_clock_enable_o));

// [sim/pcg_top_tb.sv]
// Purpose: Self-checking bench for the clock gate and reset controller
// Assumes: Zero-wait AHB-Lite slave; tick random in bus tests, steady when timing
// Notes: Expected values come from the register layout, never from the design
`timescale 1ns/1ps
module pcg_top_tb;
    logic        clk_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic        pll_tick_i = 1'b1, tick_rand = 1'b1, hrdy, hresp;
    logic        acr, ace, sdc, sde;
    logic [1:0]  htrans_i = 2'h0, power_mode_i = 2'h0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata, q;
    logic [15:0] lf = 16'h4A7F;
    logic [7:0]  ofs [4] = '{8'h14, 8'h18, 8'h20, 8'h24};
    int          fail_count = 0, n_compared = 0;
    pcg_top pcg_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .pll_tick_i(pll_tick_i), .power_mode_i(power_mode_i), .audio_core_reset_o(acr),
        .audio_clock_enable_o(ace), .sd_clock_o(sdc), .sd_clock_enable_o(sde));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Clock, and a random tick stream that timing tests hold steady
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        lf <= nx(lf);
        pll_tick_i <= tick_rand ? lf[3] : 1'b1;
    end
    task automatic end_of_test();
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for hready; a stuck slave ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (hrdy !== 1'b1 && n < 64);
        if (hrdy !== 1'b1)
        begin
            fail_count++;
            end_of_test();
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        wait_ready();
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_ready();
        q = hrdata;
        chk({31'h0, hresp}, 32'h0); // Slave must always answer OKAY
    endtask
    // Counts samples at one level; the cap keeps a stuck clock from hanging
    task automatic count(input logic v, output int c);
        c = 0;
        while (sdc === v && c < 40)
        begin
            c++;
            @(negedge clk_i);
        end
    endtask
    task automatic period(output int hi, output int lo);
        count(1'b1, hi);
        count(1'b0, hi);
        count(1'b1, hi);
        count(1'b0, lo);
    endtask
    initial
    begin
        int h, l, hi, lo, m, g, e;
        logic [31:0] w;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b0, {24'h0, ofs[i]}, 32'h0);
            chk(q, 32'h0);
        end
        for (int i = 0; i < 6; i++)
        begin
            w = (i == 0) ? 32'hFFFF_FFFF : {lf, nx(lf)};
            xfer(1'b1, 32'h20, w);
            xfer(1'b0, 32'h20, 32'h0);
            chk(q, w & 32'h0000_0707);
        end
        xfer(1'b1, 32'h24, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h24, 32'h0);
        chk(q, 32'h0000_0101);
        xfer(1'b1, 32'h40, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h40, 32'h0);
        chk(q, 32'h0);
        $display("register access test done");
        xfer(1'b1, 32'h14, 32'h0);
        xfer(1'b1, 32'h18, 32'h1);
        xfer(1'b0, 32'h18, 32'h0);
        chk(q, 32'h1);
        chk(acr, 1'b1);
        xfer(1'b1, 32'h14, 32'h1);
        xfer(1'b1, 32'h18, 32'hFFFF_FFFE);
        repeat (6) @(posedge clk_i);
        xfer(1'b0, 32'h18, 32'h0);
        chk(q, 32'h2);
        chk(acr, 1'b0);
        xfer(1'b1, 32'h18, 32'h3);
        xfer(1'b0, 32'h18, 32'h0);
        chk(q, 32'h1);
        $display("soft reset test done");
        tick_rand <= 1'b0;
        xfer(1'b1, 32'h24, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            h = (i == 0) ? 0 : (i == 1) ? 7 : int'(lf[2:0]);
            l = (i == 0) ? 0 : (i == 1) ? 7 : int'(lf[6:4]);
            xfer(1'b1, 32'h20, {21'h0, 3'(l), 5'h0, 3'(h)});
            period(hi, lo);
            period(hi, lo);
            chk(hi, h + 1);
            chk(lo, l + 1);
        end
        $display("divider test done");
        // Mode code 3 is undefined and must leave both clocks stopped
        for (int k = 0; k < 16; k++)
        begin
            m = k / 4;
            g = k % 4;
            xfer(1'b1, 32'h24, {23'h0, g[1], 7'h0, g[0]});
            xfer(1'b1, 32'h14, {23'h0, g[1], 7'h0, g[0]});
            power_mode_i <= 2'(m);
            repeat (24) @(posedge clk_i);
            e = (m == 0 && g[0]) || (m == 1 && g[1]);
            chk(sde, e);
            chk(ace, e);
            if (e == 0) chk(sdc, 1'b0);
        end
        $display("power mode test done");
        // A reset in mid-run must clear the SD gate and park the divided clock low
        resetn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        xfer(1'b0, 32'h24, 32'h0);
        chk(q, 32'h0);
        chk(sdc, 1'b0);
        chk(sde, 1'b0);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule
